// ===== dv/sbl_host_model.sv
// Host model that drives the serial link of the bootstrap loader
`timescale 1ns/10ps
module sbl_host_model #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic core_clk,
	output logic      serial_receive_pin,
	input  wire logic txd
);
	// ****************************************
	// Link tasks
	// ****************************************
	// Line idles high, as its pull-up would hold it
	initial serial_receive_pin = 1'b1;

	// one start bit, eight data bits, one stop bit at a standard-like rate
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			#1 serial_receive_pin = f[i];
			repeat (BIT_CLKS - 1) @(posedge core_clk);
		end
	endtask : send_byte

	// the identification byte is taken before any code goes out
	task automatic recv_byte(output logic [7:0] b, output bit ok);
		int n;
		n = 0;
		b = 8'h00;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		// Sample each bit in its middle
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge core_clk);
			#1 b[i] = txd;
		end
		ok = (n < 4000);
	endtask : recv_byte
endmodule : sbl_host_model

// ===== dv/tb_top.sv
// Self-checking testbench for the serial bootstrap loader
`timescale 1ns/10ps
module tb_top;
	localparam int P = 64;
	logic        core_clk, sys_rst, hw_reset_done, sw_reset, boot_select_pin, reduced_variant, mem_req_code;
	logic        external_access_select_pin, rom_seg1_map, rom_present, ram_wr_ready = 1'b0;
	logic        serial_receive_pin, serial_transmit_pin_o, serial_transmit_pin_oe, transmit_pin_direction_bit;
	logic        bootstrap_loader_mode, watchdog_disable, watchdog_reset_block, preset_load, baud_overflow;
	logic [15:0] context_pointer, stack_pointer, stack_underflow_limit, stack_overflow_limit;
	logic [15:0] serial_control_register, system_configuration_register;
	logic [12:0] baud_reload_value;
	logic        route_boot_rom, route_user_rom, route_external, route_undefined, ram_wr_en, cpu_jump;
	logic [23:0] mem_req_addr, ram_wr_addr, cpu_jump_addr, last_jump;
	logic [7:0]  ram_wr_data, id_seen, b;
	logic [31:0] got_q[$];
	logic [7:0]  exp_q[$];
	int          fails = 0, check_count = 0, jumps = 0, n;
	integer      seed = 32'h73FC2320;
	bit          ok, rdy_hold = 1'b0;

	sbl_loader i_sbl_loader (.core_clk, .sys_rst, .hw_reset_done, .sw_reset, .boot_select_pin, .reduced_variant,
		.external_access_select_pin, .rom_seg1_map, .rom_present, .serial_receive_pin, .serial_transmit_pin_o,
		.serial_transmit_pin_oe, .transmit_pin_direction_bit, .bootstrap_loader_mode, .watchdog_disable,
		.watchdog_reset_block, .preset_load, .context_pointer, .stack_pointer, .stack_underflow_limit,
		.stack_overflow_limit, .serial_control_register, .system_configuration_register, .baud_reload_value,
		.baud_overflow, .mem_req_addr, .mem_req_code, .route_boot_rom, .route_user_rom, .route_external,
		.route_undefined, .ram_wr_en, .ram_wr_addr, .ram_wr_data, .ram_wr_ready, .cpu_jump, .cpu_jump_addr);
	sbl_host_model #(.BIT_CLKS(P)) i_sbl_host_model (.core_clk, .serial_receive_pin, .txd(serial_transmit_pin_o));

	// ****************************************
	// Clock, far-side stall and monitors
	// ****************************************
	// Free running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// RAM port stalls while the code bytes arrive, then answers at random
	always @(posedge core_clk) ram_wr_ready <= #1 rdy_hold ? 1'b0 : 1'($random(seed));
	// Collect accepted RAM writes and jumps
	always @(posedge core_clk) begin
		if ((ram_wr_en & ram_wr_ready) === 1'b1) got_q.push_back({ram_wr_addr, ram_wr_data});
		if (cpu_jump === 1'b1) begin
			jumps++;
			last_jump = cpu_jump_addr;
		end
	end

	// ****************************************
	// Helper tasks
	// ****************************************
	task automatic tick(input int k = 1);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic finish_test();
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	// Reset pulse, then end of hardware reset with the given strap
	task automatic boot(input logic strap, input logic red);
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		boot_select_pin = strap;
		reduced_variant = red;
		hw_reset_done = 1'b1;
		tick();
		hw_reset_done = 1'b0;
	endtask : boot
	// Random fetches and reads against the routing model
	task automatic route_test(input bit m);
		logic [3:0] e;
		logic       w;
		for (int i = 0; i < 32; i++) begin
			mem_req_addr = 24'($random(seed)) & 24'h01FFFF;
			{mem_req_code, external_access_select_pin, rom_seg1_map, rom_present} = 4'($random(seed));
			w = (mem_req_addr[23:16] == {7'h00, rom_seg1_map}) && !mem_req_addr[15];
			if (!m) e = {1'b0, w & external_access_select_pin, !(w & external_access_select_pin),
				w & external_access_select_pin & !rom_present};
			else if (w && mem_req_code) e = 4'h8;
			else if (w) e = {3'b010, !rom_present};
			else e = 4'h2;
			tick();
			chk("route", e, {route_boot_rom, route_user_rom, route_external, route_undefined});
		end
	endtask : route_test

	// ****************************************
	// Test sequence
	// ****************************************
	// Timeout guard, nearly three times the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		finish_test();
	end
	initial begin
		{sys_rst, hw_reset_done, sw_reset, boot_select_pin, reduced_variant, mem_req_code} = 6'h21;
		{external_access_select_pin, rom_seg1_map, rom_present, mem_req_addr} = 27'h0;
		boot(1'b1, 1'b0);
		chk("mode", 1'b0, bootstrap_loader_mode);
		chk("jump", {1'b1, 24'h000000}, {cpu_jump, cpu_jump_addr});
		route_test(1'b0);
		boot(1'b0, 1'b1);
		chk("mode", 1'b0, bootstrap_loader_mode);
		boot(1'b0, 1'b0);
		chk("entry", 5'h1F, {bootstrap_loader_mode, preset_load, serial_transmit_pin_oe,
			transmit_pin_direction_bit, serial_transmit_pin_o});
		chk("watchdog", 2'h3, {watchdog_disable, watchdog_reset_block});
		chk("presets", {16'hFA00, 16'hFA40, 16'hFA40, 16'hFA0C, 16'h8011, 16'h0E00}, {context_pointer,
			stack_pointer, stack_underflow_limit, stack_overflow_limit, serial_control_register,
			system_configuration_register});
		tick();
		chk("preset pulse", 1'b0, preset_load);
		route_test(1'b1);
		fork
			i_sbl_host_model.send_byte(8'h00);
			i_sbl_host_model.recv_byte(id_seen, ok);
		join
		chk("reload", (9 * P / 4 - 36) / 72, baud_reload_value);
		chk("overflow", 1'b0, baud_overflow);
		chk("ident", {1'b1, sbl_pkg::ID_BYTE_DEFAULT}, {ok, id_seen});
		tick(2 * P);
		jumps = 0;
		rdy_hold = 1'b1;
		for (int i = 0; i < 32; i++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			i_sbl_host_model.send_byte(b);
		end
		rdy_hold = 1'b0;
		n = 0;
		while (jumps == 0 && n < 5000) begin
			tick();
			n++;
		end
		chk("jump", {32'h1, 24'h00FA40}, {jumps, last_jump});
		chk("mode", 1'b1, bootstrap_loader_mode);
		chk("writes", 32, got_q.size());
		foreach (exp_q[i]) chk("ram write", {24'(24'h00FA40 + i), exp_q[i]}, got_q[i]);
		sw_reset = 1'b1;
		tick();
		sw_reset = 1'b0;
		chk("mode", 1'b0, bootstrap_loader_mode);
		route_test(1'b0);
		finish_test();
	end
endmodule : tb_top

// ===== hw/sbl_fifo.sv
// Byte FIFO between the serial receiver and the RAM writer
`timescale 1ns/10ps
module sbl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0]   count;
	} sbl_fifo_s;

	sbl_fifo_s        st_q;
	sbl_fifo_s        st_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic             push;
	logic             pop;

	// Honest full and empty flags
	assign in_ready  = (st_q.count != (AW+1)'(DEPTH)); // Level is one bit wider than the pointers
	assign out_valid = (st_q.count != '0);
	assign out_data  = mem_q[st_q.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and level update
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.wr_ptr = st_q.wr_ptr + AW'(1);
		end
		if (pop) begin
			st_d.rd_ptr = st_q.rd_ptr + AW'(1);
		end
		if (push && !pop) begin
			st_d.count = st_q.count + (AW+1)'(1);
		end else if (pop && !push) begin
			st_d.count = st_q.count - (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Storage array, written on push only
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[st_q.wr_ptr] <= in_data;
		end
	end
endmodule : sbl_fifo

// ===== hw/sbl_loader.sv
// Bootstrap loader mode control, baud measurement, code load and ROM redirect
`timescale 1ns/10ps
// How it works
// - Strap low at end of hardware reset enters boot mode.
// - Boot mode entry does not depend on bus configuration.
// - Boot mode watches receive pin for one zero byte from host.
// - Reload factor computed from zero byte; transmit pin becomes output.
// - Identification byte sent at derived rate.
// - Watchdog held disabled throughout boot mode.
// - Register presets and transmit pin plus direction driven high on entry.
// - No code executes from user ROM during boot mode.
// - Receiver enabled after identification byte; accepts 32 bytes.
// - Bytes written in order to RAM FA40 through FA5F.
// - After 32nd byte jump to FA40, staying in boot mode.
// - External access select pin ignored in boot mode.
// - Code fetches in ROM window served by boot ROM.
// - Data reads go to user ROM, undefined without ROM.
// - Boot ROM follows ROM window into segment 1.
// - Software reset, or hardware reset with strap high, leaves boot mode.
// - After leaving boot mode fetching restarts at address zero.
// - Reload equals timer count minus 36, divided by 72.
// - Reduced variant treats strap as inactive; no boot mode.
// - No watchdog reset while in boot mode.
module sbl_loader #(
	parameter logic [7:0] ID_BYTE = sbl_pkg::ID_BYTE_DEFAULT
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        hw_reset_done,
	input  wire logic        sw_reset,
	input  wire logic        boot_select_pin,
	input  wire logic        reduced_variant,
	input  wire logic        external_access_select_pin,
	input  wire logic        rom_seg1_map,
	input  wire logic        rom_present,
	input  wire logic        serial_receive_pin,
	output logic             serial_transmit_pin_o,
	output logic             serial_transmit_pin_oe,
	output logic             transmit_pin_direction_bit,
	output logic             bootstrap_loader_mode,
	output logic             watchdog_disable,
	output logic             watchdog_reset_block,
	output logic             preset_load,
	output logic [15:0]      context_pointer,
	output logic [15:0]      stack_pointer,
	output logic [15:0]      stack_underflow_limit,
	output logic [15:0]      stack_overflow_limit,
	output logic [15:0]      serial_control_register,
	output logic [15:0]      system_configuration_register,
	output logic [12:0]      baud_reload_value,
	output logic             baud_overflow,
	input  wire logic [23:0] mem_req_addr,
	input  wire logic        mem_req_code,
	output logic             route_boot_rom,
	output logic             route_user_rom,
	output logic             route_external,
	output logic             route_undefined,
	output logic             ram_wr_en,
	output logic [23:0]      ram_wr_addr,
	output logic [7:0]       ram_wr_data,
	input  wire logic        ram_wr_ready,
	output logic             cpu_jump,
	output logic [23:0]      cpu_jump_addr
);
	typedef struct packed {
		sbl_pkg::sbl_state_e state;
		logic                mode;
		logic                preset;
		logic                rx_prev;
		logic [1:0]          presc;
		logic [15:0]         timer;
		logic                ovf;
		logic [15:0]         rem;
		logic [12:0]         quot;
		logic [12:0]         reload;
		logic                tx_start;
		logic [5:0]          count;
		logic                wr_en;
		logic [23:0]         wr_addr;
		logic [7:0]          wr_data;
		logic                jump;
		logic [23:0]         jump_addr;
		logic                r_boot;
		logic                r_user;
		logic                r_ext;
		logic                r_undef;
	} sbl_loader_s;

	sbl_loader_s st_q;
	sbl_loader_s st_d;
	logic        tx_busy;
	logic        uart_txd;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	logic        in_window;
	logic        load_done;

	// ****************************************
	// Serial channel and receive buffer
	// ****************************************
	sbl_uart u_uart (
		.core_clk           (core_clk),
		.sys_rst            (sys_rst),
		.baud_reload_value  (st_q.reload),
		.tx_start           (st_q.tx_start),
		.tx_data            (ID_BYTE),
		.rx_enable          ((st_q.state == sbl_pkg::ST_LOAD) && fifo_in_ready),
		.serial_receive_pin (serial_receive_pin),
		.txd                (uart_txd),
		.tx_busy            (tx_busy),
		.rx_valid           (rx_valid),
		.rx_data            (rx_data)
	);

	sbl_fifo #(
		.WIDTH (sbl_pkg::FIFO_WIDTH),
		.DEPTH (sbl_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (rx_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ****************************************
	// Outputs
	// ****************************************
	// watchdog held off
	assign watchdog_disable              = st_q.mode;
	assign watchdog_reset_block          = st_q.mode;
	assign bootstrap_loader_mode         = st_q.mode;
	// transmit pin driven as output in boot mode
	assign serial_transmit_pin_o         = st_q.mode ? uart_txd : 1'b1;
	assign serial_transmit_pin_oe        = st_q.mode;
	assign transmit_pin_direction_bit    = st_q.mode;
	assign preset_load                   = st_q.preset;
	assign context_pointer               = sbl_pkg::CONTEXT_POINTER_PRESET;
	assign stack_pointer                 = sbl_pkg::STACK_POINTER_PRESET;
	assign stack_underflow_limit         = sbl_pkg::STACK_UNDERFLOW_PRESET;
	assign stack_overflow_limit          = sbl_pkg::STACK_OVERFLOW_PRESET;
	assign serial_control_register       = sbl_pkg::SERIAL_CONTROL_PRESET;
	assign system_configuration_register = sbl_pkg::SYSTEM_CONFIG_PRESET;
	assign baud_reload_value             = st_q.reload;
	assign baud_overflow                 = st_q.ovf;
	assign route_boot_rom                = st_q.r_boot;
	assign route_user_rom                = st_q.r_user;
	assign route_external                = st_q.r_ext;
	assign route_undefined               = st_q.r_undef;
	assign ram_wr_en                     = st_q.wr_en;
	assign ram_wr_addr                   = st_q.wr_addr;
	assign ram_wr_data                   = st_q.wr_data;
	assign cpu_jump                      = st_q.jump;
	assign cpu_jump_addr                 = st_q.jump_addr;

	assign in_window = (mem_req_addr[23:16] == (rom_seg1_map ? sbl_pkg::ROM_SEG1 : sbl_pkg::ROM_SEG0))
		&& (mem_req_addr[15:0] <= sbl_pkg::ROM_WIN_END);
	// Stall buffer while a RAM write waits or the load is complete
	assign load_done      = (st_q.count == sbl_pkg::LOAD_COUNT);
	assign fifo_out_ready = (st_q.state == sbl_pkg::ST_LOAD) && !load_done
		&& (!st_q.wr_en || ram_wr_ready);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		st_d          = st_q;
		st_d.preset   = 1'b0;
		st_d.tx_start = 1'b0;
		st_d.jump     = 1'b0;
		st_d.rx_prev  = serial_receive_pin;
		if (st_q.wr_en && ram_wr_ready) begin
			st_d.wr_en = 1'b0;
		end
		case (st_q.state)
			sbl_pkg::ST_WAIT_START: begin
				if (st_q.rx_prev && !serial_receive_pin) begin
					st_d.state = sbl_pkg::ST_MEASURE;
					st_d.timer = '0;
					st_d.presc = '0;
					st_d.ovf   = 1'b0;
				end
			end
			sbl_pkg::ST_MEASURE: begin
				st_d.presc = st_q.presc + 2'h1;
				if (st_q.presc == sbl_pkg::TIMER_PRESCALE_LAST) begin
					st_d.timer = st_q.timer + 16'h0001;
					if (st_q.timer == sbl_pkg::TIMER_MAX) begin
						st_d.ovf = 1'b1;
					end
				end
				// stop at stop-bit rise, subtract offset
				if (!st_q.rx_prev && serial_receive_pin) begin
					st_d.state = sbl_pkg::ST_DIVIDE;
					st_d.quot  = '0;
					st_d.rem   = (st_q.timer > sbl_pkg::MEAS_OFFSET) ? st_q.timer - sbl_pkg::MEAS_OFFSET : '0;
				end
			end
			sbl_pkg::ST_DIVIDE: begin
				if (st_q.rem >= sbl_pkg::MEAS_DIVISOR) begin
					st_d.rem  = st_q.rem - sbl_pkg::MEAS_DIVISOR;
					st_d.quot = st_q.quot + 13'h0001;
				end else begin
					st_d.reload   = st_q.quot;
					st_d.tx_start = 1'b1;
					st_d.state    = sbl_pkg::ST_SEND_ID;
				end
			end
			sbl_pkg::ST_SEND_ID: begin
				if (!st_q.tx_start && !tx_busy) begin
					st_d.state = sbl_pkg::ST_LOAD;
					st_d.count = '0;
				end
			end
			sbl_pkg::ST_LOAD: begin
				if (fifo_out_valid && fifo_out_ready) begin
					st_d.wr_en   = 1'b1;
					st_d.wr_addr = sbl_pkg::LOAD_BASE + {18'h0, st_q.count};
					st_d.wr_data = fifo_out_data;
					st_d.count   = st_q.count + sbl_pkg::LOAD_STEP;
				end
				if (load_done && !st_q.wr_en) begin
					st_d.jump      = 1'b1;
					st_d.jump_addr = sbl_pkg::LOAD_BASE;
					st_d.state     = sbl_pkg::ST_RUN;
				end
			end
			default: begin
			end
		endcase
		if (sw_reset) begin
			st_d.mode      = 1'b0;
			st_d.state     = sbl_pkg::ST_NORMAL;
			st_d.wr_en     = 1'b0;
			st_d.jump      = 1'b1;
			st_d.jump_addr = sbl_pkg::RESET_VECTOR;
		end else if (hw_reset_done) begin
			// strap sampled at end of reset
			st_d.mode   = !boot_select_pin && !reduced_variant;
			st_d.wr_en  = 1'b0;
			st_d.count  = '0;
			st_d.reload = '0;
			if (!boot_select_pin && !reduced_variant) begin
				st_d.preset = 1'b1;
				st_d.state  = sbl_pkg::ST_WAIT_START;
			end else begin
				st_d.state     = sbl_pkg::ST_NORMAL;
				st_d.jump      = 1'b1;
				st_d.jump_addr = sbl_pkg::RESET_VECTOR;
			end
		end
		st_d.r_boot  = st_q.mode && in_window && mem_req_code;
		st_d.r_user  = in_window && (st_q.mode ? !mem_req_code : external_access_select_pin);
		st_d.r_ext   = st_q.mode ? !in_window : !(in_window && external_access_select_pin);
		st_d.r_undef = st_d.r_user && !rom_present;
	end

	// Receive edge detector starts at the idle line level, so no false edge follows reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q         <= '0;
			st_q.rx_prev <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	AST_ENTER: assert property (hw_reset_done && !sw_reset && !boot_select_pin && !reduced_variant
		|=> bootstrap_loader_mode && preset_load)
		else $error("boot mode not entered");
	AST_REDUCED: assert property (hw_reset_done && reduced_variant |=> !bootstrap_loader_mode)
		else $error("reduced variant entered boot mode");
	AST_SW_EXIT: assert property (sw_reset |=> !bootstrap_loader_mode && cpu_jump
		&& cpu_jump_addr == sbl_pkg::RESET_VECTOR)
		else $error("software reset did not exit");
	AST_HW_EXIT: assert property (hw_reset_done && !sw_reset && boot_select_pin
		|=> !bootstrap_loader_mode && cpu_jump && cpu_jump_addr == sbl_pkg::RESET_VECTOR)
		else $error("hardware exit vector wrong");
	AST_WDT: assert property ($rose(bootstrap_loader_mode) |-> watchdog_disable && watchdog_reset_block)
		else $error("watchdog active in boot mode");
	AST_TXPIN: assert property (preset_load |-> serial_transmit_pin_oe && serial_transmit_pin_o
		&& transmit_pin_direction_bit)
		else $error("transmit pin not preset");
	AST_BOOTROM: assert property (bootstrap_loader_mode && mem_req_code && in_window && !sw_reset
		&& !hw_reset_done |=> route_boot_rom && !route_user_rom)
		else $error("code fetch not redirected");
	AST_DATA: assert property (bootstrap_loader_mode && !mem_req_code && in_window && !sw_reset
		&& !hw_reset_done |=> route_user_rom && (route_undefined == !$past(rom_present)))
		else $error("data read misrouted");
	AST_RAMADDR: assert property (ram_wr_en |-> ram_wr_addr >= sbl_pkg::LOAD_BASE
		&& ram_wr_addr <= sbl_pkg::LOAD_LAST)
		else $error("RAM write outside load area");
	// jump to load base in boot mode
	AST_JUMP: assert property (cpu_jump && bootstrap_loader_mode |-> cpu_jump_addr == sbl_pkg::LOAD_BASE
		##1 (bootstrap_loader_mode || $past(sw_reset) || $past(hw_reset_done)))
		else $error("bad jump after load");
	AST_RXGATE: assert property (rx_valid |-> st_q.state == sbl_pkg::ST_LOAD)
		else $error("byte received outside load phase");

	COV_ENTER: cover property (hw_reset_done && !boot_select_pin ##1 bootstrap_loader_mode);
	COV_LOADED: cover property (cpu_jump && bootstrap_loader_mode);
	COV_OVF: cover property ($rose(baud_overflow));
	COV_REDIRECT: cover property (route_boot_rom);
endmodule : sbl_loader

// ===== hw/sbl_pkg.sv
// Constants and types shared by the serial bootstrap loader files
package sbl_pkg;
	// ****************************************
	// Presets loaded on entry to boot mode
	// ****************************************
	localparam logic [15:0] CONTEXT_POINTER_PRESET   = 16'hFA00;
	localparam logic [15:0] STACK_POINTER_PRESET     = 16'hFA40;
	localparam logic [15:0] STACK_UNDERFLOW_PRESET   = 16'hFA40;
	localparam logic [15:0] STACK_OVERFLOW_PRESET    = 16'hFA0C;
	localparam logic [15:0] SERIAL_CONTROL_PRESET    = 16'h8011;
	localparam logic [15:0] SYSTEM_CONFIG_PRESET     = 16'h0E00;
	// Arbitrary neutral identification value
	localparam logic [7:0]  ID_BYTE_DEFAULT          = 8'h3C;

	// ****************************************
	// Load area and vectors
	// ****************************************
	localparam logic [23:0] LOAD_BASE                = 24'h00FA40;
	localparam logic [23:0] LOAD_LAST                = 24'h00FA5F;
	localparam logic [23:0] RESET_VECTOR             = 24'h000000;
	localparam logic [5:0]  LOAD_COUNT               = 6'h20;
	localparam logic [5:0]  LOAD_STEP                = 6'h01;

	// ****************************************
	// Internal ROM window
	// ****************************************
	localparam logic [7:0]  ROM_SEG0                 = 8'h00;
	localparam logic [7:0]  ROM_SEG1                 = 8'h01;
	localparam logic [15:0] ROM_WIN_END              = 16'h7FFF;

	// ****************************************
	// Baud measurement and serial timing
	// ****************************************
	localparam logic [15:0] MEAS_OFFSET              = 16'h0024;
	localparam logic [15:0] MEAS_DIVISOR             = 16'h0048;
	localparam logic [15:0] TIMER_MAX                = 16'hFFFF;
	localparam logic [1:0]  TIMER_PRESCALE_LAST      = 2'h3;
	localparam logic [3:0]  PHASE_MID                = 4'h7;
	localparam logic [3:0]  PHASE_LAST               = 4'hF;
	localparam logic [3:0]  BIT_STOP                 = 4'h9;
	localparam int          FIFO_WIDTH               = 8;
	localparam int          FIFO_DEPTH               = 32;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_WAIT_START,
		ST_MEASURE,
		ST_DIVIDE,
		ST_SEND_ID,
		ST_LOAD,
		ST_RUN
	} sbl_state_e;
endpackage : sbl_pkg

// ===== hw/sbl_uart.sv
// Serial channel: baud generator, transmitter and receiver
`timescale 1ns/10ps
module sbl_uart (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [12:0] baud_reload_value,
	input  wire logic        tx_start,
	input  wire logic [7:0]  tx_data,
	input  wire logic        rx_enable,
	input  wire logic        serial_receive_pin,
	output logic             txd,
	output logic             tx_busy,
	output logic             rx_valid,
	output logic [7:0]       rx_data
);
	typedef struct packed {
		logic [13:0] brg_cnt;
		logic        tx_busy;
		logic [9:0]  tx_sh;
		logic [3:0]  tx_bit;
		logic [3:0]  tx_ph;
		logic        rx_busy;
		logic [7:0]  rx_sh;
		logic [3:0]  rx_bit;
		logic [3:0]  rx_ph;
		logic        rx_valid;
		logic [7:0]  rx_data;
	} sbl_uart_s;

	sbl_uart_s st_q;
	sbl_uart_s st_d;
	logic      tick;

	// Sixteen ticks per bit, one tick every 2*(reload+1) clocks
	assign tick     = (st_q.brg_cnt == '0);
	assign txd      = st_q.tx_sh[0];
	assign tx_busy  = st_q.tx_busy;
	assign rx_valid = st_q.rx_valid;
	assign rx_data  = st_q.rx_data;

	always_comb begin
		st_d          = st_q;
		st_d.rx_valid = 1'b0;
		st_d.brg_cnt  = tick ? {baud_reload_value, 1'b1} : st_q.brg_cnt - 14'h0001;
		// Transmitter: start, eight data bits LSB first, stop
		if (tx_start && !st_q.tx_busy) begin
			st_d.tx_busy = 1'b1;
			st_d.tx_sh   = {1'b1, tx_data, 1'b0};
			st_d.tx_bit  = '0;
			st_d.tx_ph   = '0;
		end else if (tick && st_q.tx_busy) begin
			st_d.tx_ph = st_q.tx_ph + 4'h1;
			if (st_q.tx_ph == sbl_pkg::PHASE_LAST) begin
				if (st_q.tx_bit == sbl_pkg::BIT_STOP) begin
					st_d.tx_busy = 1'b0;
				end else begin
					st_d.tx_sh  = {1'b1, st_q.tx_sh[9:1]};
					st_d.tx_bit = st_q.tx_bit + 4'h1;
				end
			end
		end
		// Receiver: samples each bit at mid phase
		if (tick) begin
			if (!st_q.rx_busy) begin
				if (rx_enable && !serial_receive_pin) begin
					st_d.rx_busy = 1'b1;
					st_d.rx_bit  = '0;
					st_d.rx_ph   = '0;
				end
			end else begin
				st_d.rx_ph = st_q.rx_ph + 4'h1;
				if (st_q.rx_ph == sbl_pkg::PHASE_MID) begin
					if (st_q.rx_bit == '0) begin
						// False start bit is dropped
						st_d.rx_busy = !serial_receive_pin;
					end else if (st_q.rx_bit == sbl_pkg::BIT_STOP) begin
						st_d.rx_busy  = 1'b0;
						st_d.rx_valid = serial_receive_pin;
						st_d.rx_data  = st_q.rx_sh;
					end else begin
						st_d.rx_sh = {serial_receive_pin, st_q.rx_sh[7:1]};
					end
				end
				if (st_q.rx_ph == sbl_pkg::PHASE_LAST) begin
					st_d.rx_bit = st_q.rx_bit + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q       <= '0;
			st_q.tx_sh <= 10'h3FF;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : sbl_uart
